// File: ast_transceiver.v
// Function
// - pick internal generator or external clock
// - clock output rises mid-bit at bit rate
// - clearing tx enable sets buffer empty
// - rx disable keeps rx flags and data
// - pending byte moves to shifter, flag set
// - stop bit checks buffer, chains next frame
// - empty at stop: end flag, line high
// - start detect, LSB-first shift, parity, stop
// - count ones against selected parity
// - check first stop bit only
// - overrun keeps data out of holding
// - good frame stored, full flag set
// - error sets flag, full flag unchanged
// - framing error still stores character
// - parity error discards character
// - reception halts while errors stand
// - sync on falling start, sample eighth tick
// - frame format from mode bits
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.vh"

module ast_transceiver (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // serial line
  output reg txd_q,
  input wire rxd,
  // serial clock pin, split
  input wire serial_clock_pin_in,
  output reg serial_clock_pin_out_q,
  output reg serial_clock_pin_oe_q,
  // event requests, levels
  output reg tx_empty_irq_q,
  output reg tx_end_irq_q,
  output reg rx_full_irq_q,
  output reg rx_error_irq_q
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA = 3'd2;
  localparam [2:0] ST_PAR = 3'd3;
  localparam [2:0] ST_STOP1 = 3'd4;
  localparam [2:0] ST_STOP2 = 3'd5;

  // external source when the high select bit is set
  function ext_clock;
    input [`AST_CTRL_W-1:0] c;
    begin
      ext_clock = c[`AST_CTRL_CKS_HI];
    end
  endfunction

  // decode of an apb offset
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  reg [`AST_MODE_W-1:0] mode_reg_q;
  reg [`AST_CTRL_W-1:0] control_reg_q;
  reg [15:0] div_q;
  reg [7:0] tx_data_holding_q;
  reg [7:0] rx_data_holding_q;
  reg tx_buffer_empty_flag_q;
  reg tx_end_flag_q;
  reg rx_buffer_full_flag_q;
  reg overrun_error_flag_q;
  reg framing_error_flag_q;
  reg parity_error_flag_q;
  reg [2:0] tx_st_q;
  reg [3:0] tx_sub_q;
  reg [2:0] tx_idx_q;
  reg [7:0] tx_shifter_q;
  reg tx_par_q;
  reg [2:0] rx_st_q;
  reg [3:0] rx_sub_q;
  reg [2:0] rx_idx_q;
  reg [7:0] rx_shifter_q;
  reg rx_par_q;
  reg rxd_prev_q;
  reg [31:0] rdata_d;
  wire tick;

  wire wr_en = psel & penable & pready_q & pwrite;
  wire wr_txd = wr_en & hit(paddr, `AST_OFF_TXD);
  wire wr_stat = wr_en & hit(paddr, `AST_OFF_STAT);
  wire tx_on = control_reg_q[`AST_CTRL_TX_ON];
  wire rx_on = control_reg_q[`AST_CTRL_RX_ON];
  wire chr7 = mode_reg_q[`AST_MODE_CHR7];
  wire mproc = mode_reg_q[`AST_MODE_MPROC];
  wire extra_bit = mode_reg_q[`AST_MODE_PAR_ON] | mproc;
  wire [2:0] last_idx = chr7 ? 3'd6 : 3'd7;
  wire [7:0] tx_mask = chr7 ? 8'h7f : 8'hff;
  wire any_err = overrun_error_flag_q | framing_error_flag_q | parity_error_flag_q;

  ast_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ext_sel(ext_clock(control_reg_q)),
    .divisor(div_q),
    .sck_in(serial_clock_pin_in),
    .tick_q(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // apb slave: pready rises in the first access cycle
  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `AST_OFF_MODE: rdata_d[`AST_MODE_W-1:0] = mode_reg_q;
      `AST_OFF_CTRL: rdata_d[`AST_CTRL_W-1:0] = control_reg_q;
      `AST_OFF_STAT: rdata_d[5:0] = {tx_end_flag_q, parity_error_flag_q, framing_error_flag_q,
                                     overrun_error_flag_q, rx_buffer_full_flag_q, tx_buffer_empty_flag_q};
      `AST_OFF_TXD: rdata_d[7:0] = tx_data_holding_q;
      `AST_OFF_RXD: rdata_d[7:0] = rx_data_holding_q;
      `AST_OFF_DIV: rdata_d[15:0] = div_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // answer latched at setup so every bus output is a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & (paddr > `AST_OFF_DIV | paddr[1:0] != 2'b00);
      prdata_q <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // software-written configuration
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg_q <= `AST_MODE_RST;
      control_reg_q <= `AST_CTRL_RST;
      div_q <= `AST_DIV_RST;
      tx_data_holding_q <= 8'h00;
    end else begin
      // settings are taken any time; software keeps tx and rx off first
      if (wr_en & hit(paddr, `AST_OFF_MODE)) begin
        mode_reg_q <= pwdata[`AST_MODE_W-1:0];
      end
      if (wr_en & hit(paddr, `AST_OFF_CTRL)) begin
        control_reg_q <= pwdata[`AST_CTRL_W-1:0];
      end
      if (wr_en & hit(paddr, `AST_OFF_DIV)) begin
        div_q <= pwdata[15:0];
      end
      if (wr_txd) begin
        tx_data_holding_q <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmitter: one bit every sixteen ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= ST_IDLE;
      tx_sub_q <= 4'h0;
      tx_idx_q <= 3'd0;
      tx_shifter_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_buffer_empty_flag_q <= 1'b1;
      tx_end_flag_q <= 1'b1;
    end else if (!tx_on) begin
      tx_st_q <= ST_IDLE;
      tx_sub_q <= 4'h0;
      tx_buffer_empty_flag_q <= 1'b1;
    end else begin
      // a data write clears the empty flag; an idle load in that cycle wins, a stop-bit chain is held off
      if (wr_txd) begin
        tx_buffer_empty_flag_q <= 1'b0;
      end
      if (tx_st_q == ST_IDLE) begin
        if (!tx_buffer_empty_flag_q) begin
          tx_shifter_q <= tx_data_holding_q & tx_mask;
          tx_par_q <= mproc ? control_reg_q[`AST_CTRL_MPB]
                            : (^(tx_data_holding_q & tx_mask)) ^ mode_reg_q[`AST_MODE_PAR_ODD];
          tx_buffer_empty_flag_q <= 1'b1;
          tx_end_flag_q <= 1'b0;
          tx_sub_q <= 4'h0;
          tx_idx_q <= 3'd0;
          tx_st_q <= ST_START;
        end
      end else if (tick) begin
        tx_sub_q <= tx_sub_q + 4'h1;
        if (tx_sub_q == `AST_TICKS_LAST) begin
          case (tx_st_q)
            ST_START: begin
              tx_st_q <= ST_DATA;
            end
            ST_DATA: begin
              tx_shifter_q <= {1'b0, tx_shifter_q[7:1]};
              tx_idx_q <= tx_idx_q + 3'd1;
              if (tx_idx_q == last_idx) begin
                tx_st_q <= extra_bit ? ST_PAR : ST_STOP1;
              end
            end
            ST_PAR: begin
              tx_st_q <= ST_STOP1;
            end
            default: begin
              if (tx_st_q == ST_STOP1 && mode_reg_q[`AST_MODE_STOP2]) begin
                tx_st_q <= ST_STOP2;
              end else if (!tx_buffer_empty_flag_q && !wr_txd) begin
                // next byte waiting: chain the frame
                tx_shifter_q <= tx_data_holding_q & tx_mask;
                tx_par_q <= mproc ? control_reg_q[`AST_CTRL_MPB]
                                  : (^(tx_data_holding_q & tx_mask)) ^ mode_reg_q[`AST_MODE_PAR_ODD];
                tx_buffer_empty_flag_q <= 1'b1;
                tx_idx_q <= 3'd0;
                tx_st_q <= ST_START;
              end else begin
                tx_end_flag_q <= 1'b1;
                tx_st_q <= ST_IDLE;
              end
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver: align to falling start edge, sample on eighth tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= ST_IDLE;
      rx_sub_q <= 4'h0;
      rx_idx_q <= 3'd0;
      rx_shifter_q <= 8'h00;
      rx_par_q <= 1'b0;
      rxd_prev_q <= 1'b1;
      rx_data_holding_q <= 8'h00;
      rx_buffer_full_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
    end else begin
      rxd_prev_q <= rxd;
      // writing zero clears a flag; the hardware set below overrides it
      if (wr_stat) begin
        rx_buffer_full_flag_q <= rx_buffer_full_flag_q & pwdata[`AST_ST_RX_BUFFER_FULL_FLAG];
        overrun_error_flag_q <= overrun_error_flag_q & pwdata[`AST_ST_OER];
        framing_error_flag_q <= framing_error_flag_q & pwdata[`AST_ST_FER];
        parity_error_flag_q <= parity_error_flag_q & pwdata[`AST_ST_PER];
      end
      // rx off only stops the shifter; flags and holding stay
      if (!rx_on) begin
        rx_st_q <= ST_IDLE;
      end else if (rx_st_q == ST_IDLE) begin
        if (!any_err && rxd_prev_q && !rxd) begin
          rx_sub_q <= 4'h0;
          rx_idx_q <= 3'd0;
          rx_shifter_q <= 8'h00;
          rx_st_q <= ST_START;
        end
      end else if (tick) begin
        rx_sub_q <= rx_sub_q + 4'h1;
        if (rx_sub_q == `AST_SAMPLE_TICK) begin
          case (rx_st_q)
            ST_START: begin
              // a glitch shorter than half a bit is no start
              if (rxd) begin
                rx_st_q <= ST_IDLE;
              end
            end
            ST_DATA: begin
              rx_shifter_q[rx_idx_q] <= rxd;
            end
            ST_PAR: begin
              rx_par_q <= rxd;
            end
            ST_STOP1: begin
              // only the first stop is checked; line then returns to idle
              rx_st_q <= ST_IDLE;
              if (rx_buffer_full_flag_q) begin
                overrun_error_flag_q <= 1'b1;
                rx_buffer_full_flag_q <= 1'b1;
              end else begin
                if (!rxd) begin
                  framing_error_flag_q <= 1'b1;
                end
                if (!mproc && mode_reg_q[`AST_MODE_PAR_ON] &&
                    ((^rx_shifter_q) ^ rx_par_q) != mode_reg_q[`AST_MODE_PAR_ODD]) begin
                  parity_error_flag_q <= 1'b1;
                end else begin
                  rx_data_holding_q <= rx_shifter_q;
                  if (rxd) begin
                    rx_buffer_full_flag_q <= 1'b1;
                  end
                end
              end
            end
            default: begin
              rx_st_q <= ST_IDLE;
            end
          endcase
        end else if (rx_sub_q == `AST_TICKS_LAST) begin
          case (rx_st_q)
            ST_START: begin
              rx_st_q <= ST_DATA;
            end
            ST_DATA: begin
              rx_idx_q <= rx_idx_q + 3'd1;
              if (rx_idx_q == last_idx) begin
                rx_st_q <= extra_bit ? ST_PAR : ST_STOP1;
              end
            end
            ST_PAR: begin
              rx_st_q <= ST_STOP1;
            end
            default: begin
              rx_st_q <= rx_st_q;
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // line, clock pin and event request outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_q <= 1'b1;
      serial_clock_pin_out_q <= 1'b1;
      serial_clock_pin_oe_q <= 1'b0;
      tx_empty_irq_q <= 1'b0;
      tx_end_irq_q <= 1'b0;
      rx_full_irq_q <= 1'b0;
      rx_error_irq_q <= 1'b0;
    end else begin
      case (tx_st_q)
        ST_START: txd_q <= 1'b0;
        ST_DATA: txd_q <= tx_shifter_q[0];
        ST_PAR: txd_q <= tx_par_q;
        default: txd_q <= 1'b1; // mark when idle
      endcase
      // low for ticks 0..7, high for 8..15: rising edge at bit centre
      if (tx_st_q != ST_IDLE) begin
        serial_clock_pin_out_q <= tx_sub_q[3];
      end else if (rx_st_q != ST_IDLE) begin
        serial_clock_pin_out_q <= rx_sub_q[3];
      end else begin
        serial_clock_pin_out_q <= 1'b1;
      end
      serial_clock_pin_oe_q <= ~ext_clock(control_reg_q) & control_reg_q[`AST_CTRL_CKS_LO];
      tx_empty_irq_q <= control_reg_q[`AST_CTRL_TIE] & tx_buffer_empty_flag_q;
      tx_end_irq_q <= control_reg_q[`AST_CTRL_TX_END_IRQ_ENABLE] & tx_end_flag_q;
      rx_full_irq_q <= control_reg_q[`AST_CTRL_RIE] & rx_buffer_full_flag_q;
      rx_error_irq_q <= control_reg_q[`AST_CTRL_RIE] & any_err;
    end
  end

endmodule

`default_nettype wire

// File: ast_regs.vh
`ifndef AST_REGS_VH
`define AST_REGS_VH

// register byte offsets
`define AST_OFF_MODE 12'h000
`define AST_OFF_CTRL 12'h004
`define AST_OFF_STAT 12'h008
`define AST_OFF_TXD 12'h00c
`define AST_OFF_RXD 12'h010
`define AST_OFF_DIV 12'h014

// mode_reg fields
`define AST_MODE_CHR7 0
`define AST_MODE_PAR_ON 1
`define AST_MODE_PAR_ODD 2
`define AST_MODE_STOP2 3
`define AST_MODE_MPROC 4
`define AST_MODE_SYNC 5
`define AST_MODE_W 6

// control_reg fields
`define AST_CTRL_TX_ON 0
`define AST_CTRL_RX_ON 1
`define AST_CTRL_CKS_LO 2
`define AST_CTRL_CKS_HI 3
`define AST_CTRL_TIE 4
`define AST_CTRL_TX_END_IRQ_ENABLE 5
`define AST_CTRL_RIE 6
`define AST_CTRL_MPB 7
`define AST_CTRL_W 8

// status_reg fields
`define AST_ST_TX_BUFFER_EMPTY_FLAG 0
`define AST_ST_RX_BUFFER_FULL_FLAG 1
`define AST_ST_OER 2
`define AST_ST_FER 3
`define AST_ST_PER 4
`define AST_ST_TX_END_FLAG 5

// reset values
`define AST_MODE_RST 6'h00
`define AST_CTRL_RST 8'h00
`define AST_DIV_RST 16'h001f

// timing: ticks of the 16x clock per bit, sample point
`define AST_TICKS_LAST 4'hf
`define AST_SAMPLE_TICK 4'h7

`endif

// File: ast_tick_gen.v
`timescale 1ns/1ps
`default_nettype none

module ast_tick_gen (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // source select
  input wire ext_sel,
  input wire [15:0] divisor,
  // external 16x clock, already synchronous
  input wire sck_in,
  // one-cycle pulse at 16x bit rate
  output reg tick_q
);

  reg [15:0] cnt_q;
  reg sck_prev_q;

  // baud generator or rising edges of the external 16x clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      sck_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_in;
      if (ext_sel) begin
        cnt_q <= 16'h0000;
        tick_q <= sck_in & ~sck_prev_q;
      end else if (cnt_q >= divisor) begin
        cnt_q <= 16'h0000;
        tick_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        tick_q <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: ast_line_peer.sv
`timescale 1ns/1ps
`default_nettype none

module ast_line_peer (
  // clock
  input wire logic pclk,
  // line from the unit
  input wire logic txd_q,
  // line and 16x clock towards the unit
  output logic rxd,
  output logic ext_clk
);
  initial begin
    rxd = 1'b1;
    ext_clk = 1'b0;
  end
  //////////////////////////////////////////////////////////////////
  // free running 16x clock, never paused, not even during setup
  always @(posedge pclk) begin
    ext_clk <= ~ext_clk;
  end
  //////////////////////////////////////////////////////////////////
  // one frame, 16 clocks a bit; pb[1] adds a bit of value pb[0]
  task automatic send(input logic [7:0] d, input int nb, input logic [1:0] pb, input logic stp);
    rxd <= 1'b0;
    repeat (16) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (16) @(posedge pclk);
    end
    if (pb[1]) begin
      rxd <= pb[0];
      repeat (16) @(posedge pclk);
    end
    rxd <= stp;
    repeat (16) @(posedge pclk);
    // gap so a bad stop is never read as a fresh start
    rxd <= 1'b1;
    repeat (16) @(posedge pclk);
  endtask
  // samples each bit mid-way; w is the wait for the start edge
  task automatic grab(input int per, input int nb, input logic hp, output logic [7:0] d,
                      output logic p, output logic st, output int w);
    w = 0;
    d = 8'h00;
    p = 1'b0;
    while (txd_q !== 1'b0 && w < 4000) begin
      @(posedge pclk);
      w++;
    end
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      repeat (per) @(posedge pclk);
      d[i] = txd_q;
    end
    if (hp) begin
      repeat (per) @(posedge pclk);
      p = txd_q;
    end
    repeat (per) @(posedge pclk);
    st = txd_q;
  endtask
endmodule

`default_nettype wire

// File: ast_transceiver_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module ast_transceiver_asserts (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  // line side
  input wire logic txd_q,
  input wire logic serial_clock_pin_out_q,
  input wire logic serial_clock_pin_oe_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////
  // zero wait states: answer right after every setup cycle
  chk_ready_after_setup: assert property (psel && !penable |=> pready_q)
    else $error("no pready after setup");
  chk_ready_one_cycle: assert property (pready_q |=> !pready_q)
    else $error("pready held");
  chk_ready_in_access: assert property (pready_q |-> psel && penable)
    else $error("pready outside access");
  chk_err_with_ready: assert property (pslverr_q |-> pready_q)
    else $error("pslverr without pready");
  chk_rdata_quiet: assert property (!pready_q |-> prdata_q == 32'h0)
    else $error("prdata not zero");
  chk_bad_addr_err: assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr > 12'h014)
    |=> pslverr_q) else $error("bad address accepted");
  // any low bit stays low for the 8 clocks after it falls, whatever the divisor
  chk_start_bit_len: assert property ($fell(txd_q) |=> !txd_q [*8])
    else $error("short low bit");
  chk_sck_high_half: assert property ($rose(serial_clock_pin_out_q) && serial_clock_pin_oe_q
    |-> serial_clock_pin_out_q [*8]) else $error("short clock high");
endmodule

bind ast_transceiver ast_transceiver_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .txd_q(txd_q),
  .serial_clock_pin_out_q(serial_clock_pin_out_q), .serial_clock_pin_oe_q(serial_clock_pin_oe_q));

`default_nettype wire

// File: ast_transceiver_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.vh"

module ast_transceiver_bench;
  logic pclk, presetn, psel, penable, pwrite, rxd, ext_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q;
  logic pready_q, pslverr_q, txd_q, sck_q, sck_oe_q, txi_q, tei_q, rxi_q, eri_q;
  logic [7:0] d;
  logic p, st;
  int w;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;

  ast_transceiver dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .txd_q(txd_q), .rxd(rxd), .serial_clock_pin_in(ext_clk),
    .serial_clock_pin_out_q(sck_q), .serial_clock_pin_oe_q(sck_oe_q), .tx_empty_irq_q(txi_q),
    .tx_end_irq_q(tei_q), .rx_full_irq_q(rxi_q), .rx_error_irq_q(eri_q));
  ast_line_peer peer (.pclk(pclk), .txd_q(txd_q), .rxd(rxd), .ext_clk(ext_clk));
  //////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr_n, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr_n;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready_q !== 1'b1 && k < 64);
    rd = prdata_q;
    er = pslverr_q;
    cmp({31'h0, pready_q}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, v, r, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, exp);
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  // reset values, refused addresses, fastest baud for the rest
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rdc(`AST_OFF_STAT, 32'h21);
    rdc(`AST_OFF_CTRL, 32'h0);
    rdc(`AST_OFF_DIV, 32'h1f);
    apb(1'b0, 12'h018, 32'h0, r, e);
    cmp({e, r[30:0]}, 32'h80000000);
    apb(1'b1, 12'h002, 32'hff, r, e);
    cmp({31'h0, e}, 32'h1);
    wr(`AST_OFF_DIV, 32'h0);
  endtask
  // four frames chained back to back, then end flag with line high
  task automatic t_tx_chain();
    wr(`AST_OFF_CTRL, 32'h35);
    fork
      peer.grab(16, 8, 1'b0, d, p, st, w);
      wr(`AST_OFF_TXD, 32'ha5);
    join
    cmp({23'h0, st, d}, 32'h1a5);
    wr(`AST_OFF_TXD, 32'h3c);
    peer.grab(16, 8, 1'b0, d, p, st, w);
    cmp({23'h0, st, d}, 32'h13c);
    cmp({31'h0, txi_q}, 32'h1);
    rdc(`AST_OFF_TXD, 32'h3c);
    fork
      peer.grab(16, 8, 1'b0, d, p, st, w);
      wr(`AST_OFF_TXD, 32'h81);
    join
    cmp({23'h0, st, d}, 32'h181);
    cmp({31'h0, sck_oe_q}, 32'h1);
    wr(`AST_OFF_TXD, 32'h7e);
    peer.grab(16, 8, 1'b0, d, p, st, w);
    cmp({23'h0, st, d}, 32'h17e);
    cmp(w, 32'h00000005);
    repeat (24) @(posedge pclk);
    cmp({28'h0, txd_q, tei_q, txi_q, 1'b1}, 32'hf);
    rdc(`AST_OFF_STAT, 32'h21);
  endtask
  // 7 bits, even parity, two stops; bit 7 must stay off the line
  task automatic t_tx_format();
    wr(`AST_OFF_CTRL, 32'h0);
    rdc(`AST_OFF_STAT, 32'h21);
    wr(`AST_OFF_MODE, 32'h0b);
    wr(`AST_OFF_CTRL, 32'h01);
    fork
      peer.grab(16, 7, 1'b1, d, p, st, w);
      wr(`AST_OFF_TXD, 32'hd5);
    join
    cmp({22'h0, p, st, d}, 32'h155);
    // let both stops run out, else tx off mid-frame leaves the end flag clear
    repeat (30) @(posedge pclk);
    rdc(`AST_OFF_STAT, 32'h21);
    // multiprocessor format: extra bit carries the control bit, parity ignored
    wr(`AST_OFF_CTRL, 32'h0);
    wr(`AST_OFF_MODE, 32'h12);
    wr(`AST_OFF_CTRL, 32'h81);
    fork
      peer.grab(16, 8, 1'b1, d, p, st, w);
      wr(`AST_OFF_TXD, 32'h0f);
    join
    cmp({22'h0, p, st, d}, 32'h30f);
    repeat (14) @(posedge pclk);
    rdc(`AST_OFF_STAT, 32'h21);
  endtask
  // odd parity receive, then rx off keeps flags and data
  task automatic t_rx_good();
    wr(`AST_OFF_CTRL, 32'h0);
    wr(`AST_OFF_MODE, 32'h06);
    wr(`AST_OFF_CTRL, 32'h42);
    peer.send(8'h96, 8, {1'b1, ~^8'h96}, 1'b1);
    rdc(`AST_OFF_STAT, 32'h23);
    rdc(`AST_OFF_RXD, 32'h96);
    cmp({31'h0, rxi_q}, 32'h1);
    wr(`AST_OFF_CTRL, 32'h0);
    rdc(`AST_OFF_STAT, 32'h23);
    rdc(`AST_OFF_RXD, 32'h96);
  endtask
  // overrun, halt while flagged, resume after clearing
  task automatic t_rx_overrun();
    wr(`AST_OFF_CTRL, 32'h42);
    peer.send(8'h11, 8, {1'b1, ~^8'h11}, 1'b1);
    rdc(`AST_OFF_STAT, 32'h27);
    cmp({31'h0, eri_q}, 32'h1);
    peer.send(8'h22, 8, {1'b1, ~^8'h22}, 1'b1);
    rdc(`AST_OFF_STAT, 32'h27);
    rdc(`AST_OFF_RXD, 32'h96);
    wr(`AST_OFF_STAT, 32'h0);
    peer.send(8'h22, 8, {1'b1, ~^8'h22}, 1'b1);
    rdc(`AST_OFF_RXD, 32'h22);
  endtask
  // parity error discards, framing error still stores
  task automatic t_rx_errors();
    wr(`AST_OFF_STAT, 32'h0);
    peer.send(8'h33, 8, {1'b1, ^8'h33}, 1'b1);
    rdc(`AST_OFF_STAT, 32'h31);
    rdc(`AST_OFF_RXD, 32'h22);
    wr(`AST_OFF_STAT, 32'h0);
    peer.send(8'h5a, 8, {1'b1, ~^8'h5a}, 1'b0);
    rdc(`AST_OFF_STAT, 32'h29);
    rdc(`AST_OFF_RXD, 32'h5a);
  endtask
  // external 16x clock toggling every clock: 32 clocks a bit
  task automatic t_ext_clock();
    wr(`AST_OFF_CTRL, 32'h0);
    wr(`AST_OFF_MODE, 32'h0); // sync select left clear: free clock is legal
    wr(`AST_OFF_CTRL, 32'h09);
    fork
      peer.grab(32, 8, 1'b0, d, p, st, w);
      wr(`AST_OFF_TXD, 32'hc3);
    join
    cmp({22'h0, sck_oe_q, st, d}, 32'h1c3);
  endtask
  //////////////////////////////////////////////////////////////////
  // clock, hang limit and main sequence
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      $display("mismatch at %0t: run too long", $time);
      tally_and_finish();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_tx_chain();
    t_tx_format();
    t_rx_good();
    t_rx_overrun();
    t_rx_errors();
    t_ext_clock();
    tally_and_finish();
  end
endmodule

`default_nettype wire
